/* byte_fifo.sv */
// small valid/ready byte fifo
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[AW-1:0]];
  // storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  // pointers; flush drops content when carrier goes away
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* host_model.sv */
// behavioural host that sends serial commands and collects replies
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // command stream towards the device
  output logic cmd_valid,
  output logic [7:0] cmd,
  output logic cmd_bad,
  // reply stream from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  // stall control
  input wire logic slow
);
  logic [7:0] rx_q[$]; // reply bytes taken so far, drained by the bench

  // idle levels before the first command
  initial begin
    cmd_valid = 1'b0;
    cmd = 8'h00;
    cmd_bad = 1'b0;
    tx_ready = 1'b1;
  end

  // one-byte command, a single-cycle strobe launched at a falling edge
  task automatic send(input logic [7:0] code, input logic bad);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = code;
    cmd_bad = bad;
    @(negedge clk);
    cmd_valid = 1'b0;
    // released bus shows the inverse so a stale byte is never mistaken
    cmd = ~code;
    cmd_bad = ~bad;
  endtask

  // take a byte on each accepted edge
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rx_q.push_back(tx_byte);
    end
  end

  // a slow host stalls at random, so replies must stand until taken
  always @(negedge clk) begin
    tx_ready <= slow ? ($urandom_range(0, 3) != 0) : 1'b1;
  end
endmodule
`default_nettype wire

/* test_tunnel_write_exclusive_ctrl.sv */
// self-checking bench for the tunnel write relay and exclusive control
`timescale 1ns/100ps
`default_nettype none
`include "tunnel_consts.svh"
module test_tunnel_write_exclusive_ctrl;
  logic clk = 0, rst_n = 0, is_uart = 1, carrier = 1, card = 0, slow = 0;
  logic rf_start = 0, rf_bv = 0, rf_end = 0, rf_rdy = 1, ser_op = 0, ser_done = 0;
  logic [7:0] rf_byte = 8'h00;
  logic [15:0] wait_set = 16'h0064; // uart wait of 100 cycles
  logic [63:0] card_id = 64'h0123456789abcdef; // arbitrary identifier
  wire logic hcv, hcb, htv, htl, htr, rtv, rtl, irq, excl;
  wire logic [7:0] hc, htb, rtb;
  int fail_count = 0, num_checks = 0, irq_count = 0, n = 0, c = 0;
  logic [7:0] rf_q[$], exp_q[$], e[$]; // seen reader bytes, model of replies

  tunnel_write_exclusive_ctrl #(.DEPTH(8), .UART_WAIT_CYC(400)) i_tunnel_write_exclusive_ctrl (
    .CLK(clk), .RESET_N(rst_n), .HOST_IS_UART(is_uart), .CARRIER_ON(carrier),
    .CARD_FORMAT(card), .PROXIMITY_CARD_IDENTIFIER(card_id), .RF_START(rf_start),
    .RF_BYTE_VALID(rf_bv), .RF_BYTE(rf_byte), .RF_END(rf_end), .RF_TX_VALID(rtv),
    .RF_TX_BYTE(rtb), .RF_TX_LAST(rtl), .RF_TX_READY(rf_rdy), .HOST_CMD_VALID(hcv),
    .HOST_CMD(hc), .HOST_CMD_BAD(hcb), .HOST_SERIAL_OP(ser_op),
    .HOST_SERIAL_DONE(ser_done), .HOST_TX_VALID(htv), .HOST_TX_BYTE(htb),
    .HOST_TX_LAST(htl), .HOST_TX_READY(htr), .IRQ(irq), .EXCLUSIVE(excl),
    .UART_WAIT_TIME_SETTING(wait_set));

  host_model i_host_model (.clk(clk), .cmd_valid(hcv), .cmd(hc), .cmd_bad(hcb),
    .tx_valid(htv), .tx_byte(htb), .tx_last(htl), .tx_ready(htr), .slow(slow));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // collect reader replies and count interrupt pulses
  always @(posedge clk) begin
    if (rtv && rf_rdy) rf_q.push_back(rtb);
    if (irq) irq_count++;
  end

  // reader side stalls too when slow, so the reply must hold
  always @(negedge clk) begin
    rf_rdy <= slow ? ($urandom_range(0, 2) != 0) : 1'b1;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a bound ran out: count it and close the run
  task automatic timeout(input string what);
    fail_count++;
    $display("ERROR %s expected response seen none", what);
    give_verdict();
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  // reader tunnel write: CLA INS P1 P2 Lc data, data mirrored into the model
  task automatic rf_cmd(input int lc);
    logic [7:0] b[$];
    logic [15:0] a;
    a = 16'($urandom);
    b = '{8'h00, 8'hd6, a[15:8], a[7:0], lc[7:0]};
    exp_q = '{`RSP_QUERY, a[15:8], a[7:0], lc[7:0]};
    for (int i = 0; i < lc; i++) begin
      b.push_back(8'($urandom));
      exp_q.push_back(b[$]);
    end
    rf_start = 1;
    @(negedge clk);
    rf_start = 0;
    foreach (b[i]) begin
      rf_bv = 1;
      rf_byte = b[i];
      @(negedge clk);
      rf_bv = 0;
    end
    rf_end = 1;
    @(negedge clk);
    rf_end = 0;
  endtask

  // wait for a whole reply under a bound, then compare byte by byte
  task automatic expect_bytes(input string what, input logic [7:0] x[$], ref logic [7:0] g[$]);
    int k = 0;
    while (g.size() < x.size() && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) timeout(what);
    tick(6);
    check({what, " count"}, 16'(x.size()), 16'(g.size()));
    foreach (x[i]) if (i < g.size()) check(what, x[i], g[i]);
    g.delete();
  endtask

  // cycles until the next interrupt pulse, bounded
  task automatic wait_irq(input int bound, output int k);
    int c0;
    c0 = irq_count;
    k = 0;
    while (irq_count == c0 && k < bound) begin
      @(negedge clk);
      k++;
    end
    if (k == bound) timeout("irq");
  endtask

  initial begin
    void'($urandom(59));
    tick(5);
    rst_n = 1;
    tick(6); // carrier synchroniser settles

    // uart host, type b, slow host and reader, early command then full relay
    slow = 1;
    rf_cmd(1 + $urandom_range(0, 7));
    check("exclusive after start", 1, excl);
    i_host_model.send(8'h33, 1'b0);
    expect_bytes("early busy", '{`RSP_BUSY}, i_host_model.rx_q);
    wait_irq(400, n);
    wait_irq(400, n);
    check("uart irq repeat", 1, n >= 96 && n <= 104);
    i_host_model.send(8'h55, 1'b0);
    expect_bytes("busy after irq", '{`RSP_BUSY}, i_host_model.rx_q);
    i_host_model.send(`CMD_QUERY, 1'b1);
    expect_bytes("bad command", '{`RSP_ERR_PARITY}, i_host_model.rx_q);
    i_host_model.send(`CMD_QUERY, 1'b0);
    i_host_model.send(8'h55, 1'b0); // lands while the reply is still going out
    expect_bytes("query reply", exp_q, i_host_model.rx_q);
    i_host_model.send(`CMD_ANSWER_OK, 1'b0);
    check("exclusive before reply", 1, excl);
    expect_bytes("answer status", '{`RSP_STATUS_OK}, i_host_model.rx_q);
    expect_bytes("reader words", '{`SW_OK1, `SW_OK2}, rf_q);
    check("exclusive after reply", 0, excl);
    $display("test uart relay done");

    // sync host, card format, early command, no repeat, error answer
    slow = 0;
    is_uart = 0;
    card = 1;
    rf_cmd(8);
    i_host_model.send(8'h44, 1'b0);
    expect_bytes("sync busy", '{`RSP_BUSY}, i_host_model.rx_q);
    wait_irq(80, n);
    check("sync irq delay", 1, n >= 28 && n <= 48);
    c = irq_count;
    tick(300);
    check("sync irq silent", 16'(c), 16'(irq_count));
    i_host_model.send(`CMD_QUERY, 1'b0);
    expect_bytes("sync query reply", exp_q, i_host_model.rx_q);
    i_host_model.send(`CMD_ANSWER_ERR, 1'b0);
    expect_bytes("error status", '{`RSP_STATUS_ERR}, i_host_model.rx_q);
    e = '{`RSP_CARD_WRITE};
    for (int i = 7; i >= 0; i--) e.push_back(card_id[8*i +: 8]);
    e.push_back(`FLAG_ERR);
    e.push_back(`FLAG_ERR);
    expect_bytes("card reply", e, rf_q);
    $display("test sync card relay done");

    // host serial operation locks out reader and host alike
    card = 0;
    ser_op = 1;
    tick(1);
    ser_op = 0;
    c = irq_count;
    rf_cmd(2);
    i_host_model.send(8'h55, 1'b0);
    tick(100);
    expect_bytes("serial silent host", '{}, i_host_model.rx_q);
    expect_bytes("serial silent reader", '{}, rf_q);
    check("serial no irq", 16'(c), 16'(irq_count));
    check("serial exclusive", 1, excl);
    ser_done = 1;
    tick(1);
    ser_done = 0;
    tick(4);
    check("serial released", 0, excl);
    $display("test serial lockout done");

    // carrier loss while awaiting query
    rf_cmd(3);
    wait_irq(100, n);
    carrier = 0;
    tick(8);
    check("carrier loss idle", 0, excl);
    carrier = 1;
    tick(8);
    $display("test carrier loss done");

    // zero length is refused with the length status and no interrupt
    c = irq_count;
    rf_cmd(0);
    expect_bytes("zero length", '{`SW_LEN1, `SW_LEN2}, rf_q);
    check("zero length no irq", 16'(c), 16'(irq_count));
    $display("test zero length done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* tunnel_consts.svh */
// constants for the tunnel write relay and exclusive control block
`ifndef TUNNEL_CONSTS_SVH
`define TUNNEL_CONSTS_SVH
`define CMD_QUERY 8'h28
`define CMD_ANSWER_OK 8'hf8
`define CMD_ANSWER_ERR 8'he8
`define RSP_QUERY 8'h18
`define RSP_CARD_WRITE 8'h09
`define RSP_ERR_PARITY 8'h06
`define RSP_BUSY 8'h01
`define RSP_STATUS_OK 8'h00
`define RSP_STATUS_ERR 8'h01
`define LC_MIN 8'h01
`define LC_MAX 8'hf8
`define SW_OK1 8'h90
`define SW_OK2 8'h00
`define SW_LEN1 8'h67
`define SW_LEN2 8'h00
`define FLAG_OK 8'h00
`define FLAG_ERR 8'hff
`define CLK_MHZ 40
`define REIRQ_NS 1000
`define REIRQ_CYC ((`REIRQ_NS * `CLK_MHZ) / 1000)
`define CARD_ID_BYTES 8
`endif

/* tunnel_pkg.sv */
// types for the tunnel write relay block
package tunnel_pkg;
  // gray codes along idle -> receive -> wait -> irq -> query -> answer -> reply
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RF_RX = 3'b001,
    ST_PRE_IRQ = 3'b011,
    ST_AWAIT_QUERY = 3'b010,
    ST_QUERY_TX = 3'b110,
    ST_AWAIT_ANSWER = 3'b111,
    ST_RF_TX = 3'b101,
    ST_SERIAL = 3'b100
  } tunnel_state_t;
endpackage

/* tunnel_write_exclusive_ctrl.sv */
// tunnel write relay with exclusive control between reader and host
// Function
// - length byte accepted only 1 to 248
// - QUERY reply: 0x18, address, length, data
// - address sent high byte first, byte units
// - ANSWER acknowledged with one status byte
// - card reply: 0x09, identifier, two flags
// - operation in progress locks out others
// - lock lasts until response finished
// - tunnel lock ends after reader reply
// - host parity/checksum error gets 0x06
// - unimplemented host command gets BUSY
// - host operation ignores all other commands
// - host command during tunnel gets BUSY
// - silent between QUERY/ANSWER and their replies (code stays silent only until the QUERY reply is sent)
// - host handling depends on IRQ already raised
// - UART early command: BUSY, IRQ after wait
// - after IRQ non-QUERY commands get BUSY
// - sync early command: BUSY, IRQ after 1us
// - UART repeats IRQ, sync does not
// - carrier loss returns to idle
`timescale 1ns/100ps
`default_nettype none
`include "tunnel_consts.svh"
module tunnel_write_exclusive_ctrl
  import tunnel_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int UART_WAIT_CYC = 400
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // configuration and carrier
  input wire logic HOST_IS_UART,
  input wire logic CARRIER_ON,
  input wire logic CARD_FORMAT,
  input wire logic [63:0] PROXIMITY_CARD_IDENTIFIER,
  // reader command stream (from rf framing)
  input wire logic RF_START,
  input wire logic RF_BYTE_VALID,
  input wire logic [7:0] RF_BYTE,
  input wire logic RF_END,
  // reader response stream
  output logic RF_TX_VALID,
  output logic [7:0] RF_TX_BYTE,
  output logic RF_TX_LAST,
  input wire logic RF_TX_READY,
  // host command stream
  input wire logic HOST_CMD_VALID,
  input wire logic [7:0] HOST_CMD,
  input wire logic HOST_CMD_BAD,
  input wire logic HOST_SERIAL_OP,
  input wire logic HOST_SERIAL_DONE,
  // host response stream
  output logic HOST_TX_VALID,
  output logic [7:0] HOST_TX_BYTE,
  output logic HOST_TX_LAST,
  input wire logic HOST_TX_READY,
  // notification and status
  output logic IRQ,
  output logic EXCLUSIVE,
  input wire logic [15:0] UART_WAIT_TIME_SETTING
);
  localparam int REIRQ_CYC = `REIRQ_CYC;

  tunnel_state_t state_r, state_nxt;
  logic carrier_s1_r, carrier_s2_r, carrier_s3_r; // pin synchroniser
  logic carrier_r; // filtered carrier level
  logic [3:0] hdr_cnt_r; // reader header byte count
  logic [15:0] addr_r; // write start address
  logic [7:0] len_r; // write length
  logic len_bad_r; // length out of range
  logic [7:0] data_cnt_r; // data bytes received
  logic irq_r; // irq output
  logic irq_done_r; // irq has been raised for this command
  logic [15:0] wait_r; // irq delay counter
  logic [3:0] tx_idx_r; // reply byte index
  logic answer_ok_r; // host answered normal end
  logic [7:0] qsent_r; // query data bytes launched so far
  logic resp_sent_r; // query header done
  logic [2:0] qidx_r; // query header index

  // fifo carries data bytes from reader to host
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_out_data;
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk(CLK), .reset_n(RESET_N), .flush(!carrier_r),
    .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(RF_BYTE),
    .out_valid(f_out_valid), .out_ready(f_out_ready), .out_data(f_out_data)
  );

  // length check for the data block
  function automatic logic len_ok(input logic [7:0] l);
    len_ok = (l >= `LC_MIN) && (l <= `LC_MAX);
  endfunction

  // carrier passes three flops; a change counts once second and third agree
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      carrier_s1_r <= 1'b0;
      carrier_s2_r <= 1'b0;
      carrier_s3_r <= 1'b0;
      carrier_r <= 1'b0;
    end else begin
      carrier_s1_r <= CARRIER_ON;
      carrier_s2_r <= carrier_s1_r;
      carrier_s3_r <= carrier_s2_r;
      if (carrier_s2_r == carrier_s3_r) carrier_r <= carrier_s3_r;
    end
  end

  // decodes of the host command
  wire host_query = HOST_CMD_VALID && !HOST_CMD_BAD && (HOST_CMD == `CMD_QUERY);
  wire host_answer = HOST_CMD_VALID && !HOST_CMD_BAD &&
    ((HOST_CMD == `CMD_ANSWER_OK) || (HOST_CMD == `CMD_ANSWER_ERR));
  // header bytes CLA INS P1 P2 Lc, then data
  wire in_hdr = (hdr_cnt_r < 4'd5);
  wire data_byte = (state_r == ST_RF_RX) && RF_BYTE_VALID && !in_hdr;
  assign f_in_valid = data_byte;
  wire rx_done = (state_r == ST_RF_RX) && RF_END;
  wire wait_done = HOST_IS_UART ? (wait_r >= UART_WAIT_TIME_SETTING)
                                : (wait_r >= 16'(REIRQ_CYC));
  // silent windows: query reception through its reply, and host serial operation
  wire silent = (state_r == ST_QUERY_TX) || (state_r == ST_SERIAL);
  wire tunnel_busy = (state_r == ST_RF_RX) || (state_r == ST_PRE_IRQ) ||
    (state_r == ST_AWAIT_QUERY) || (state_r == ST_RF_TX) ||
    ((state_r == ST_AWAIT_ANSWER) && !host_answer);
  // a host command refused with busy or 0x06
  wire refuse = HOST_CMD_VALID && !silent && tunnel_busy &&
    !((state_r == ST_AWAIT_QUERY) && host_query);
  wire reply_done = RF_TX_VALID && RF_TX_READY && RF_TX_LAST;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (RF_START) state_nxt = ST_RF_RX;
        else if (HOST_SERIAL_OP) state_nxt = ST_SERIAL;
      end
      ST_RF_RX: if (rx_done) state_nxt = len_bad_r ? ST_RF_TX : ST_PRE_IRQ;
      ST_PRE_IRQ: if (wait_done) state_nxt = ST_AWAIT_QUERY;
      ST_AWAIT_QUERY: if (host_query) state_nxt = ST_QUERY_TX;
      ST_QUERY_TX: if (HOST_TX_VALID && HOST_TX_READY && HOST_TX_LAST)
        state_nxt = ST_AWAIT_ANSWER;
      ST_AWAIT_ANSWER: if (host_answer) state_nxt = ST_RF_TX;
      ST_RF_TX: if (reply_done) state_nxt = ST_IDLE;
      ST_SERIAL: if (HOST_SERIAL_DONE) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (!carrier_r && state_r != ST_IDLE && state_r != ST_SERIAL)
      state_nxt = ST_IDLE;
  end

  // state register and reader header capture
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_IDLE;
      hdr_cnt_r <= '0;
      addr_r <= '0;
      len_r <= '0;
      len_bad_r <= 1'b0;
      data_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (RF_START && state_r == ST_IDLE) begin
        hdr_cnt_r <= '0;
        data_cnt_r <= '0;
      end else if (state_r == ST_RF_RX && RF_BYTE_VALID) begin
        if (in_hdr) hdr_cnt_r <= hdr_cnt_r + 4'd1;
        else data_cnt_r <= data_cnt_r + 8'd1;
        if (hdr_cnt_r == 4'd2) addr_r[15:8] <= RF_BYTE;
        if (hdr_cnt_r == 4'd3) addr_r[7:0] <= RF_BYTE;
        if (hdr_cnt_r == 4'd4) begin
          len_r <= RF_BYTE;
          len_bad_r <= !len_ok(RF_BYTE);
        end
      end
    end
  end

  // irq: uart waits the programmed time, sync about 1us; uart repeats
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_r <= 1'b0;
      irq_done_r <= 1'b0;
      wait_r <= '0;
    end else if (state_r == ST_PRE_IRQ || state_r == ST_AWAIT_QUERY) begin
      if (refuse && state_r == ST_PRE_IRQ) wait_r <= '0;
      else if (!wait_done) wait_r <= wait_r + 16'd1;
      if (state_r == ST_PRE_IRQ && wait_done) begin
        irq_r <= 1'b1;
        irq_done_r <= 1'b1;
        wait_r <= '0;
      end else if (state_r == ST_AWAIT_QUERY && HOST_IS_UART && wait_done) begin
        irq_r <= 1'b1;
        wait_r <= '0;
      end else begin
        irq_r <= 1'b0;
      end
    end else begin
      irq_r <= 1'b0;
      irq_done_r <= 1'b0;
      wait_r <= '0;
    end
  end

  // host reply byte selection
  logic [7:0] qbyte;
  always_comb begin
    case (qidx_r)
      3'd0: qbyte = `RSP_QUERY;
      3'd1: qbyte = addr_r[15:8];
      3'd2: qbyte = addr_r[7:0];
      default: qbyte = len_r;
    endcase
  end
  wire in_query_data = (state_r == ST_QUERY_TX) && resp_sent_r;
  // pop exactly when a data byte is loaded, so the fifo and the wire stay in step
  assign f_out_ready = in_query_data && (!HOST_TX_VALID || (HOST_TX_VALID && HOST_TX_READY)) &&
    !HOST_TX_LAST;
  wire tx_fire = HOST_TX_VALID && HOST_TX_READY;

  // host transmit: busy/error replies, query reply, answer status
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOST_TX_VALID <= 1'b0;
      HOST_TX_BYTE <= '0;
      HOST_TX_LAST <= 1'b0;
      qidx_r <= '0;
      resp_sent_r <= 1'b0;
      answer_ok_r <= 1'b0;
      qsent_r <= '0;
    end else begin
      if (tx_fire) HOST_TX_VALID <= 1'b0;
      if (refuse) begin
        HOST_TX_VALID <= 1'b1;
        HOST_TX_LAST <= 1'b1;
        HOST_TX_BYTE <= HOST_CMD_BAD ? `RSP_ERR_PARITY : `RSP_BUSY;
      end else if (host_answer && state_r == ST_AWAIT_ANSWER) begin
        answer_ok_r <= (HOST_CMD == `CMD_ANSWER_OK);
        HOST_TX_VALID <= 1'b1;
        HOST_TX_LAST <= 1'b1;
        HOST_TX_BYTE <= (HOST_CMD == `CMD_ANSWER_OK) ? `RSP_STATUS_OK
                                                      : `RSP_STATUS_ERR;
      end else if (state_r == ST_QUERY_TX && (!HOST_TX_VALID || tx_fire)) begin
        if (!resp_sent_r) begin
          HOST_TX_VALID <= 1'b1;
          HOST_TX_BYTE <= qbyte;
          HOST_TX_LAST <= 1'b0;
          qidx_r <= qidx_r + 3'd1;
          if (qidx_r == 3'd3) resp_sent_r <= 1'b1;
        end else if (f_out_valid && !HOST_TX_LAST) begin
          HOST_TX_VALID <= 1'b1;
          HOST_TX_BYTE <= f_out_data;
          HOST_TX_LAST <= ((qsent_r + 8'd1) == len_r);
          qsent_r <= qsent_r + 8'd1;
        end
      end else if (state_r != ST_QUERY_TX) begin
        qidx_r <= '0;
        resp_sent_r <= 1'b0;
        qsent_r <= '0;
        if (tx_fire) HOST_TX_LAST <= 1'b0;
      end
    end
  end

  // reader reply: card format sends code, identifier, two flags
  wire [3:0] rf_len = CARD_FORMAT ? 4'(`CARD_ID_BYTES + 2) : 4'd1;
  logic [7:0] rbyte;
  always_comb begin
    if (CARD_FORMAT) begin
      if (tx_idx_r == 4'd0) rbyte = `RSP_CARD_WRITE;
      else if (tx_idx_r <= 4'(`CARD_ID_BYTES))
        rbyte = PROXIMITY_CARD_IDENTIFIER[8*(`CARD_ID_BYTES-tx_idx_r) +: 8];
      else rbyte = answer_ok_r ? `FLAG_OK : `FLAG_ERR;
    end else if (len_bad_r) begin
      rbyte = (tx_idx_r == 4'd0) ? `SW_LEN1 : `SW_LEN2;
    end else begin
      rbyte = (tx_idx_r == 4'd0) ? (answer_ok_r ? `SW_OK1 : `SW_LEN1) : `SW_OK2;
    end
  end

  // reader transmit sequencer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RF_TX_VALID <= 1'b0;
      RF_TX_BYTE <= '0;
      RF_TX_LAST <= 1'b0;
      tx_idx_r <= '0;
    end else if (state_r == ST_RF_TX && carrier_r) begin
      if (!RF_TX_VALID || (RF_TX_READY && !RF_TX_LAST)) begin
        RF_TX_VALID <= 1'b1;
        RF_TX_BYTE <= rbyte;
        RF_TX_LAST <= (tx_idx_r == rf_len);
        tx_idx_r <= tx_idx_r + 4'd1;
      end else if (reply_done) begin
        RF_TX_VALID <= 1'b0;
        RF_TX_LAST <= 1'b0;
      end
    end else begin
      RF_TX_VALID <= 1'b0;
      RF_TX_LAST <= 1'b0;
      tx_idx_r <= '0;
    end
  end

  // exclusive flag and irq outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXCLUSIVE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      EXCLUSIVE <= (state_nxt != ST_IDLE);
      IRQ <= irq_r;
    end
  end

  // assertions
  a_busy_code: assert property (@(posedge CLK) disable iff (!RESET_N)
    refuse && !HOST_CMD_BAD |=> HOST_TX_BYTE == `RSP_BUSY)
    else $error("busy code wrong");
  a_parity_code: assert property (@(posedge CLK) disable iff (!RESET_N)
    refuse && HOST_CMD_BAD |=> HOST_TX_BYTE == `RSP_ERR_PARITY)
    else $error("parity error code wrong");
  a_silent_serial: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == ST_SERIAL |-> !refuse)
    else $error("reply during host operation");
  a_carrier_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
    !carrier_r && state_r == ST_AWAIT_QUERY |=> state_r == ST_IDLE)
    else $error("carrier loss not handled");
  a_exclusive_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == ST_RF_RX |-> ##1 EXCLUSIVE)
    else $error("exclusive flag missing");
  a_query_head: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(state_r == ST_QUERY_TX) |=> HOST_TX_BYTE == `RSP_QUERY)
    else $error("query code wrong");
  a_len_check: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == ST_RF_RX && RF_BYTE_VALID && hdr_cnt_r == 4'd4 && RF_BYTE == 8'h00
    |=> len_bad_r)
    else $error("zero length accepted");
  a_query_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == ST_AWAIT_QUERY && HOST_CMD_VALID && !HOST_CMD_BAD && !host_query
    |-> refuse)
    else $error("non query not refused");
  a_sync_norepeat: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == ST_AWAIT_QUERY && $past(state_r == ST_AWAIT_QUERY) && !HOST_IS_UART
    |-> !irq_r)
    else $error("sync irq repeated");
endmodule
`default_nettype wire
